// ---- rtl/tsacmb_map.svh ----
// constants for the two-speed angle combiner host controller
`ifndef TSACMB_MAP_SVH
`define TSACMB_MAP_SVH
`define TSACMB_FINE_BITS 14
`define TSACMB_COARSE_BITS 7
`define TSACMB_OUT_BITS 19
`define TSACMB_CLK_PERIOD_NS 10
`define TSACMB_SETTLE_NS 500
`define TSACMB_SETTLE_CYC ((`TSACMB_SETTLE_NS + `TSACMB_CLK_PERIOD_NS - 1) / `TSACMB_CLK_PERIOD_NS)
`define TSACMB_RATIO_36 2'h0
`define TSACMB_RATIO_18 2'h1
`define TSACMB_RATIO_9 2'h2
`endif

// ---- rtl/tsacmb_pkg.sv ----
// types for the two-speed angle combiner host controller
package tsacmb_pkg;
   typedef logic [1:0] tsacmb_ratio_t;
   typedef enum logic [1:0] {
      TSACMB_IDLE = 2'h0,
      TSACMB_WAIT = 2'h1,
      TSACMB_SETTLE = 2'h3,
      TSACMB_TAKE = 2'h2
   } tsacmb_state_e;
endpackage

// ---- rtl/tsacmb_hold.sv ----
// result holding register for the captured angle word
`timescale 1ns/10ps
module tsacmb_hold #(
   parameter int WIDTH = 19
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic wr,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   always_ff @(posedge clk)
   begin
      if (rst)
         dout <= '0;
      else if (ce && wr)
         dout <= din;
   end
endmodule

// ---- rtl/tsacmb_host.sv ----
// host controller that reads the combined coarse/fine angle word
`timescale 1ns/10ps
`include "tsacmb_map.svh"
module tsacmb_host #(
   parameter int OUT_BITS = `TSACMB_OUT_BITS,
   parameter int SETTLE_CYC = `TSACMB_SETTLE_CYC,
   parameter bit USE_INHIBIT = 1'b0
) (
   input wire logic SYS_CLK,
   input wire logic SRST,
   input wire logic CE,
   input wire logic [1:0] RATIO_SEL,
   input wire logic READ_REQ,
   input wire logic FINE_BUSY,
   input wire logic COARSE_BUSY,
   input wire logic [OUT_BITS-1:0] COMB_ANGLE,
   output logic INHIBIT_ALL,
   output logic READ_DONE,
   output logic [OUT_BITS-1:0] ANGLE_OUT
);
   import tsacmb_pkg::*;

   tsacmb_state_e state_r;
   tsacmb_state_e state_nxt;
   logic [15:0] cnt_r;
   logic busy_any;
   logic take;
   logic [OUT_BITS-1:0] aligned;

   // the top one or two bits of the result are cleared in place, by the ratio
   function automatic logic [OUT_BITS-1:0] align_word(
      input logic [OUT_BITS-1:0] w, input tsacmb_ratio_t r);
      logic [OUT_BITS-1:0] m;
      m = w;
      if (r == `TSACMB_RATIO_18)
         m = {1'b0, w[OUT_BITS-2:0]};
      else if (r == `TSACMB_RATIO_9)
         m = {2'b00, w[OUT_BITS-3:0]};
      return m;
   endfunction

   assign busy_any = FINE_BUSY | COARSE_BUSY;
   assign take = (state_r == TSACMB_TAKE);
   assign aligned = align_word(COMB_ANGLE, tsacmb_ratio_t'(RATIO_SEL));

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         TSACMB_IDLE:
            if (READ_REQ)
               state_nxt = TSACMB_WAIT;
         TSACMB_WAIT:
            if (USE_INHIBIT || !busy_any)
               state_nxt = TSACMB_SETTLE;
         TSACMB_SETTLE:
            if (!USE_INHIBIT && busy_any)
               state_nxt = TSACMB_WAIT;
            else if (cnt_r >= 16'(SETTLE_CYC - 1))
               state_nxt = TSACMB_TAKE;
         TSACMB_TAKE:
            state_nxt = TSACMB_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
         state_r <= TSACMB_IDLE;
      else if (CE)
         state_r <= state_nxt;
   end

   // settle counter runs only inside the settle state
   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
         cnt_r <= 16'h0;
      else if (CE)
      begin
         if (state_r == TSACMB_SETTLE && state_nxt == TSACMB_SETTLE)
            cnt_r <= cnt_r + 16'h1;
         else
            cnt_r <= 16'h0;
      end
   end

   // freeze both converters together from wait until the take
   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
         INHIBIT_ALL <= 1'b0;
      else if (CE)
         INHIBIT_ALL <= USE_INHIBIT && (state_nxt == TSACMB_WAIT ||
            state_nxt == TSACMB_SETTLE || state_nxt == TSACMB_TAKE);
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (SRST)
         READ_DONE <= 1'b0;
      else if (CE)
         READ_DONE <= take;
   end

   // the combiner itself does fine dominance and coarse correction
   tsacmb_hold #(.WIDTH(OUT_BITS)) u_hold (
      .clk(SYS_CLK),
      .rst(SRST),
      .ce(CE),
      .wr(take),
      .din(aligned),
      .dout(ANGLE_OUT)
   );
endmodule

// ---- verification/tsacmb_checker.sv ----
// port assertions for the angle host controller
`timescale 1ns/10ps
module tsacmb_checker #(
   parameter bit USE_INHIBIT = 1'b0
) (
   input wire logic SYS_CLK,
   input wire logic SRST,
   input wire logic [1:0] RATIO_SEL,
   input wire logic FINE_BUSY,
   input wire logic COARSE_BUSY,
   input wire logic INHIBIT_ALL,
   input wire logic READ_DONE,
   input wire logic [18:0] ANGLE_OUT
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SRST);
   sequence s_done;
      READ_DONE;
   endsequence
   a_done_pulse: assert property (s_done |=> !READ_DONE)
      else $error("done too long");
   a_out_hold: assert property (!READ_DONE |-> $stable(ANGLE_OUT))
      else $error("word moved");
   a_msb_mask: assert property (s_done ##0 RATIO_SEL == 2'h1 |-> !ANGLE_OUT[18])
      else $error("msb set");
   a_msb_nine: assert property (s_done ##0 RATIO_SEL == 2'h2 |-> ANGLE_OUT[18:17] == 2'h0)
      else $error("top bits set");
   // in busy mode the take is decided at an edge where both converters were quiet
   sequence s_gap;
      !READ_DONE [*3];
   endsequence
   a_done_gap: assert property (s_done |=> s_gap)
      else $error("done too soon");
   a_busy_quiet: assert property (USE_INHIBIT ||
      !READ_DONE || $past(!(FINE_BUSY || COARSE_BUSY), 2))
      else $error("read while busy");
   a_inh_mode: assert property (USE_INHIBIT || !INHIBIT_ALL)
      else $error("inhibit in busy mode");
endmodule
bind tsacmb_host tsacmb_checker #(.USE_INHIBIT(USE_INHIBIT)) chk (
   .SYS_CLK(SYS_CLK), .SRST(SRST), .RATIO_SEL(RATIO_SEL),
   .FINE_BUSY(FINE_BUSY), .COARSE_BUSY(COARSE_BUSY),
   .INHIBIT_ALL(INHIBIT_ALL), .READ_DONE(READ_DONE), .ANGLE_OUT(ANGLE_OUT));

// ---- verification/tsacmb_partner.sv ----
// behavioural two-speed combiner fed by the bench converters
`timescale 1ns/10ps
module tsacmb_partner (
   input wire logic [13:0] FINE,
   input wire logic [6:0] COARSE,
   input wire logic [1:0] SEL,
   output logic [18:0] COMB
);
   logic [6:0] top;
   // fine bits win, coarse pulled to the nearest agreeing value
   assign top = 7'(COARSE - FINE[13:12] + 7'h2) >> 2;
   assign #500 COMB = {top[4:0] & (5'h1f >> SEL), FINE};
endmodule

// ---- verification/testbench.sv ----
// random reads of the combined angle through the host controller
`timescale 1ns/10ps
module testbench;
   logic clk = 0, rst = 1, req = 0, fb = 0, cb = 0, done, inh;
   logic [1:0] sel = 0;
   logic [18:0] a, comb, q;
   logic [13:0] f = 0;
   logic [6:0] c = 0;
   int err_count = 0, tests_run = 0, n;
   initial forever #5 clk = ~clk;
   tsacmb_partner pm (.FINE(f), .COARSE(c), .SEL(sel), .COMB(comb));
   tsacmb_host dut (.SYS_CLK(clk), .SRST(rst), .CE(1'b1), .RATIO_SEL(sel),
      .READ_REQ(req), .FINE_BUSY(fb), .COARSE_BUSY(cb), .COMB_ANGLE(comb),
      .INHIBIT_ALL(inh), .READ_DONE(done), .ANGLE_OUT(q));
   task stop_test;
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task rd(input logic [18:0] t, input int d);
      @(posedge clk);
      a = t & (19'h7ffff >> sel);
      f <= a[13:0];
      c <= 7'(a[18:12] + d) & (7'h7f >> sel);
      fb <= 1;
      cb <= 1;
      req <= 1;
      @(posedge clk);
      req <= 0;
      fb <= 0;
      repeat (3) @(posedge clk);
      cb <= 0;
      n = 0;
      while (done !== 1'b1 && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      tests_run++;
      if (n == 300 || q !== a)
      begin
         $display("ERROR %0t angle %h want %h", $time, q, a);
         err_count++;
      end
      tests_run++;
      if (inh !== 1'b0)
      begin
         $display("ERROR %0t inhibit raised in busy mode", $time);
         err_count++;
      end
      if (n == 300)
         stop_test();
   endtask
   initial
   begin
      n = $urandom(44436);
      repeat (20) @(posedge clk);
      rst <= 0;
      rd(19'h0, -1);
      rd(19'h7ffff, 1);
      rd(19'h5a000, 0);
      for (int i = 0; i < 12; i++)
      begin
         @(posedge clk);
         sel <= 2'(i % 3);
         rd(19'($urandom), int'($urandom_range(2)) - 1);
      end
      stop_test();
   end
endmodule
